// ===== cfi_query_cfg.svh
// constants of the primary-algorithm extended query table block
`ifndef CFI_QUERY_CFG_SVH
`define CFI_QUERY_CFG_SVH

// pointer value read at main query offset 15h
`define QRY_PTR_OFFSET     8'h15
`define QRY_BASE_RST       8'h39

// entry offsets relative to the base pointer
`define QRY_REL_FIRST      8'h03
`define QRY_REL_MAJOR      8'h03
`define QRY_REL_MINOR      8'h04
`define QRY_REL_FEAT0      8'h05
`define QRY_REL_FEAT1      8'h06
`define QRY_REL_FEAT2      8'h07
`define QRY_REL_FEAT3      8'h08
`define QRY_REL_SUSP       8'h09
`define QRY_REL_PROT0      8'h0A
`define QRY_REL_PROT1      8'h0B
`define QRY_REL_VDD        8'h0C
`define QRY_REL_VPP        8'h0D
`define QRY_REL_NFIELD     8'h0E
`define QRY_REL_PADR_LO    8'h0F
`define QRY_REL_PADR_HI    8'h10
`define QRY_REL_FACT_SIZE  8'h11
`define QRY_REL_USER_SIZE  8'h12
`define QRY_REL_LAST       8'h12

// entry values, low byte of each query word
`define QRY_VAL_MAJOR      8'h31
`define QRY_VAL_MINOR      8'h30
`define QRY_VAL_FEAT0      8'hE6
`define QRY_VAL_FEAT1      8'h03
`define QRY_VAL_FEAT_HI    8'h00
`define QRY_VAL_SUSP       8'h01
`define QRY_VAL_PROT0      8'h03
`define QRY_VAL_PROT1      8'h00
`define QRY_VAL_VDD        8'h18
`define QRY_VAL_VPP        8'hC0
`define QRY_VAL_NFIELD     8'h01
`define QRY_VAL_PADR_LO    8'h80
`define QRY_VAL_PADR_HI    8'h00
`define QRY_VAL_FACT_SIZE  8'h03
`define QRY_VAL_USER_SIZE  8'h04

// command codes on the command port
`define CMD_READ_ARRAY     8'hFF
`define CMD_READ_STATUS    8'h70
`define CMD_QUERY          8'h98

// apb byte offsets
`define APB_OFF_BASE       12'h000
`define APB_OFF_ADDR       12'h004
`define APB_OFF_DATA       12'h008
`define APB_OFF_STATUS     12'h00C
`define STAT_REFUSED_BIT   3

`endif

// ===== cfi_query_pkg.sv
// types shared by the extended query table block
package cfi_query_pkg;
   typedef enum logic [1:0]
   {
      MODE_ARRAY  = 2'b00,
      MODE_STATUS = 2'b01,
      MODE_QUERY  = 2'b10
   } mode_type;
endpackage

// ===== query_lookup_if.sv
// carrier between the control logic and the query table lookup
`timescale 1ns/1ps
`default_nettype none
interface query_lookup_if;
   logic [7:0]  word_addr;
   logic [7:0]  base;
   logic [15:0] word;
   logic        hit;
   modport requester  (output word_addr, base, input word, hit);
   modport table_side (input word_addr, base, output word, hit);
endinterface // query_lookup_if
`default_nettype wire

// ===== query_table_lookup.sv
// constant lookup of the extended query words relative to the base pointer
`timescale 1ns/1ps
`default_nettype none
`include "cfi_query_cfg.svh"
module query_table_lookup
   import cfi_query_pkg::*;
(
   query_lookup_if.table_side lk   // address in, word out
);
   function automatic logic [7:0] entry_byte(input logic [7:0] rel);
      logic [7:0] b;
      b = 8'h00;
      unique case (rel)
         `QRY_REL_MAJOR:     b = `QRY_VAL_MAJOR;
         `QRY_REL_MINOR:     b = `QRY_VAL_MINOR;
         `QRY_REL_FEAT0:     b = `QRY_VAL_FEAT0;
         `QRY_REL_FEAT1:     b = `QRY_VAL_FEAT1;
         `QRY_REL_FEAT2:     b = `QRY_VAL_FEAT_HI;
         `QRY_REL_FEAT3:     b = `QRY_VAL_FEAT_HI;
         `QRY_REL_SUSP:      b = `QRY_VAL_SUSP;
         `QRY_REL_PROT0:     b = `QRY_VAL_PROT0;
         `QRY_REL_PROT1:     b = `QRY_VAL_PROT1;
         `QRY_REL_VDD:       b = `QRY_VAL_VDD;
         `QRY_REL_VPP:       b = `QRY_VAL_VPP;
         `QRY_REL_NFIELD:    b = `QRY_VAL_NFIELD;
         `QRY_REL_PADR_LO:   b = `QRY_VAL_PADR_LO;
         `QRY_REL_PADR_HI:   b = `QRY_VAL_PADR_HI;
         `QRY_REL_FACT_SIZE: b = `QRY_VAL_FACT_SIZE;
         `QRY_REL_USER_SIZE: b = `QRY_VAL_USER_SIZE;
         default:            b = 8'h00;
      endcase
      return b;
   endfunction

   logic [7:0] rel_offset;

   assign rel_offset = 8'(lk.word_addr - lk.base);
   assign lk.hit     = (rel_offset >= `QRY_REL_FIRST) && (rel_offset <= `QRY_REL_LAST);
   // upper byte always zero
   assign lk.word    = {8'h00, entry_byte(rel_offset)};
endmodule // query_table_lookup
`default_nettype wire

// ===== cfi_primary_ext_query_rom.sv
// extended query table block: command mode, query read port and apb registers
`timescale 1ns/1ps
`default_nettype none
`include "cfi_query_cfg.svh"
module cfi_primary_ext_query_rom
   import cfi_query_pkg::*;
#(
   parameter int ADDR_WIDTH = 12
)
(
   input  wire logic                  clock_in,      // 125 MHz clock
   input  wire logic                  reset_n_in,    // async reset, active low
   input  wire logic [ADDR_WIDTH-1:0] paddr_in,      // apb byte address
   input  wire logic                  psel_in,       // apb select
   input  wire logic                  penable_in,    // apb access phase
   input  wire logic                  pwrite_in,     // apb write
   input  wire logic [31:0]           pwdata_in,     // apb write data
   output logic      [31:0]           prdata_out,    // apb read data
   output logic                       pready_out,    // apb ready
   output logic                       pslverr_out,   // apb error
   input  wire logic                  cmd_valid_in,  // command strobe
   input  wire logic [7:0]            cmd_code_in,   // command code
   input  wire logic                  suspend_in,    // an operation is suspended
   input  wire logic                  rd_req_in,     // query read strobe
   input  wire logic [7:0]            rd_addr_in,    // query word offset
   output logic      [15:0]           rd_data_out,   // query read data
   output logic                       rd_valid_out,  // read data valid
   output logic                       query_mode_out // query mode active
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   mode_type    mode_reg;
   mode_type    mode_next;
   logic [7:0]  base_reg;
   logic [7:0]  addr_reg;
   logic        refused_reg;
   logic [15:0] rd_data_reg;
   logic [15:0] rd_data_next;
   logic        rd_valid_reg;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;

   query_lookup_if port_lk();
   query_lookup_if soft_lk();

   query_table_lookup u_port_lookup
   (
      .lk (port_lk)
   );

   query_table_lookup u_soft_lookup
   (
      .lk (soft_lk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // command decode

   logic cmd_array;
   logic cmd_status;
   logic cmd_query;
   logic cmd_known;
   logic cmd_refused;

   assign cmd_array   = cmd_valid_in && (cmd_code_in == `CMD_READ_ARRAY);
   assign cmd_status  = cmd_valid_in && (cmd_code_in == `CMD_READ_STATUS);
   assign cmd_query   = cmd_valid_in && (cmd_code_in == `CMD_QUERY);
   assign cmd_known   = cmd_array || cmd_status || cmd_query;
   // other commands belong to the program/erase controller; during suspend
   // they are refused here and flagged for software
   assign cmd_refused = cmd_valid_in && suspend_in && !cmd_known;

   // read commands are taken whether or not an operation is suspended
   assign mode_next = cmd_query  ? MODE_QUERY  :
                      cmd_status ? MODE_STATUS :
                      cmd_array  ? MODE_ARRAY  :
                      mode_reg;

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         mode_reg <= MODE_ARRAY;
      else
         mode_reg <= mode_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // query read port

   logic in_query;

   assign in_query           = (mode_reg == MODE_QUERY);
   assign port_lk.word_addr  = rd_addr_in;
   assign port_lk.base       = base_reg;
   // outside query mode the array or status path owns the bus, so zero here
   assign rd_data_next       = (in_query && port_lk.hit) ? port_lk.word : 16'h0000;

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rd_data_reg  <= 16'h0000;
         rd_valid_reg <= 1'b0;
      end
      else
      begin
         rd_valid_reg <= rd_req_in;
         if (rd_req_in)
            rd_data_reg <= rd_data_next;
      end
   end

   assign rd_data_out    = rd_data_reg;
   assign rd_valid_out   = rd_valid_reg;
   assign query_mode_out = in_query;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states

   logic [ADDR_WIDTH-1:0] off_base;
   logic [ADDR_WIDTH-1:0] off_addr;
   logic [ADDR_WIDTH-1:0] off_data;
   logic [ADDR_WIDTH-1:0] off_status;
   logic                  sel_base;
   logic                  sel_addr;
   logic                  sel_data;
   logic                  sel_status;
   logic                  mapped;
   logic                  setup_rd;
   logic                  access;
   logic                  wr_base;
   logic                  wr_addr;
   logic                  wr_clear;
   logic [31:0]           status_word;

   assign off_base    = ADDR_WIDTH'(`APB_OFF_BASE);
   assign off_addr    = ADDR_WIDTH'(`APB_OFF_ADDR);
   assign off_data    = ADDR_WIDTH'(`APB_OFF_DATA);
   assign off_status  = ADDR_WIDTH'(`APB_OFF_STATUS);
   assign sel_base    = (paddr_in == off_base);
   assign sel_addr    = (paddr_in == off_addr);
   assign sel_data    = (paddr_in == off_data);
   assign sel_status  = (paddr_in == off_status);
   assign mapped      = sel_base || sel_addr || sel_data || sel_status;
   assign setup_rd    = psel_in && !penable_in && !pwrite_in;
   assign access      = psel_in && penable_in;
   assign wr_base     = access && pwrite_in && sel_base;
   assign wr_addr     = access && pwrite_in && sel_addr;
   assign wr_clear    = access && pwrite_in && sel_status && pwdata_in[`STAT_REFUSED_BIT];
   assign pready_out  = 1'b1;
   assign pslverr_out = access && !mapped;

   assign soft_lk.word_addr = addr_reg;
   assign soft_lk.base      = base_reg;
   assign status_word       = {28'h0000000, refused_reg, suspend_in, mode_reg};

   assign prdata_next = sel_base   ? {24'h000000, base_reg} :
                        sel_addr   ? {24'h000000, addr_reg} :
                        sel_data   ? {16'h0000, (in_query && soft_lk.hit) ? soft_lk.word : 16'h0000} :
                        sel_status ? status_word :
                        32'h00000000;

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         base_reg   <= `QRY_BASE_RST;
         addr_reg   <= 8'h00;
         prdata_reg <= 32'h00000000;
      end
      else
      begin
         if (wr_base)
            base_reg <= pwdata_in[7:0];
         if (wr_addr)
            addr_reg <= pwdata_in[7:0];
         if (setup_rd)
            prdata_reg <= prdata_next;
      end
   end

   // a refusal in the clearing cycle survives the clear
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         refused_reg <= 1'b0;
      else if (cmd_refused)
         refused_reg <= 1'b1;
      else if (wr_clear)
         refused_reg <= 1'b0;
   end

   assign prdata_out = prdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   logic [7:0] rel_in;

   assign rel_in = 8'(rd_addr_in - base_reg);

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!reset_n_in);

   sequence q_read(logic [7:0] rel);
      rd_req_in && in_query && (rel_in == rel);
   endsequence

   a_base_write_only: assert property ($changed(base_reg) |-> $past(wr_base))
      else $error("base pointer changed without a write");
   a_major_version: assert property (q_read(8'h03) |=> rd_valid_out && rd_data_out == 16'h0031)
      else $error("major version word wrong");
   a_minor_version: assert property (q_read(8'h04) |=> rd_data_out == 16'h0030)
      else $error("minor version word wrong");
   a_feature_low_word: assert property (q_read(8'h05) |=> rd_data_out == 16'h00E6)
      else $error("feature low word wrong");
   a_feature_next_word: assert property (q_read(8'h06) |=> rd_data_out == 16'h0003)
      else $error("feature second word wrong");
   a_feature_upper_zero: assert property ((q_read(8'h07) or q_read(8'h08)) |=> rd_data_out == 16'h0000)
      else $error("feature upper words not zero");
   a_feature_bit31_clear: assert property (q_read(8'h08) |=> !rd_data_out[7])
      else $error("feature bit 31 set");
   a_suspend_word: assert property (q_read(8'h09) |=> rd_data_out == 16'h0001)
      else $error("suspend functions word wrong");
   a_query_in_suspend: assert property (suspend_in && cmd_query |=> in_query ##0 query_mode_out)
      else $error("query command lost during suspend");
   // software may clear on the very next cycle, which is legal
   a_refused_sticks: assert property (cmd_refused |=> refused_reg ##1 (refused_reg || $past(wr_clear)))
      else $error("refused flag not held");
   a_protect_status: assert property (q_read(8'h0A) |=> rd_data_out == 16'h0003)
      else $error("block protect word wrong");
   a_protect_next: assert property (q_read(8'h0B) |=> rd_data_out == 16'h0000)
      else $error("block protect upper word not zero");
   a_vdd_optimum: assert property (q_read(8'h0C) |=> rd_data_out == 16'h0018)
      else $error("logic supply word wrong");
   a_vpp_optimum: assert property (q_read(8'h0D) |=> rd_data_out == 16'h00C0)
      else $error("program supply word wrong");
   a_field_count: assert property (q_read(8'h0E) |=> rd_data_out == 16'h0001)
      else $error("protection field count wrong");
   a_prot_address: assert property (q_read(8'h0F) |=> rd_data_out == 16'h0080)
      else $error("protection address low word wrong");
   a_prot_address_hi: assert property (q_read(8'h10) |=> rd_data_out == 16'h0000)
      else $error("protection address high word wrong");
   a_factory_size: assert property (q_read(8'h11) |=> rd_data_out == 16'h0003)
      else $error("factory region size wrong");
   a_user_size: assert property (q_read(8'h12) |=> rd_data_out == 16'h0004)
      else $error("user region size wrong");
   a_upper_byte_zero: assert property (rd_valid_out |-> rd_data_out[15:8] == 8'h00)
      else $error("upper data byte not zero");
   a_no_data_outside: assert property (rd_req_in && !in_query |=> rd_data_out == 16'h0000)
      else $error("query data outside query mode");

   // window edges, mode bookkeeping and port timing
   a_outside_window: assert property ((q_read(8'h02) or q_read(8'h13)) |=> rd_data_out == 16'h0000)
      else $error("data returned outside the table window");
   a_refused_clears: assert property (wr_clear && !cmd_refused |=> !refused_reg)
      else $error("refused flag not cleared");
   a_status_in_suspend: assert property (suspend_in && cmd_status |=> mode_reg == MODE_STATUS)
      else $error("read status command lost during suspend");
   a_array_in_suspend: assert property (suspend_in && cmd_array |=> mode_reg == MODE_ARRAY && !query_mode_out)
      else $error("read array command lost during suspend");
   a_mode_holds: assert property (!cmd_known |=> $stable(mode_reg))
      else $error("mode changed without a read command");
   a_valid_pulse: assert property (rd_req_in |=> rd_valid_out)
      else $error("read valid missing after request");
   a_data_holds: assert property (!rd_req_in |=> $stable(rd_data_out))
      else $error("read data changed without a request");
   a_base_write_lands: assert property (wr_base |=> base_reg == $past(pwdata_in[7:0]))
      else $error("base pointer write lost");
   a_soft_outside: assert property (setup_rd && sel_data && !in_query |=> prdata_out == 32'h0000_0000)
      else $error("register data read outside query mode");

   // main scenarios the bench is expected to reach
   c_query_entry: cover property (cmd_query ##1 q_read(8'h03) ##1 rd_valid_out);
   c_prot_pair: cover property (q_read(8'h0F) ##2 q_read(8'h10));
   c_suspend_refuse: cover property (cmd_refused ##[1:20] wr_clear);
   c_base_moved: cover property (wr_base ##[1:20] q_read(8'h05));
   c_back_to_array: cover property (in_query ##1 cmd_array ##1 rd_req_in);

endmodule // cfi_primary_ext_query_rom
`default_nettype wire

// ===== query_host_model.sv
// host controller model issuing commands and query reads
`timescale 1ns/1ps
`default_nettype none
module query_host_model
(
   input  wire logic        clock_in,      // bench clock
   output logic             cmd_valid_out, // command strobe
   output logic [7:0]       cmd_code_out,  // command code
   output logic             rd_req_out,    // query read strobe
   output logic [7:0]       rd_addr_out,   // query word offset
   input  wire logic [15:0] rd_data_in,    // query read data
   input  wire logic        rd_valid_in    // read data valid
);
   initial
   begin
      cmd_valid_out = 1'b0;
      cmd_code_out  = 8'h00;
      rd_req_out    = 1'b0;
      rd_addr_out   = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // idle code and address are inverted so a stale value is never trusted
   task automatic send_cmd(input logic [7:0] code);
      @(posedge clock_in);
      cmd_valid_out <= 1'b1;
      cmd_code_out  <= code;
      @(posedge clock_in);
      cmd_valid_out <= 1'b0;
      cmd_code_out  <= ~code;
      @(posedge clock_in);
   endtask
   task automatic q_read(input logic [7:0] addr, output logic [15:0] data, output logic valid);
      @(posedge clock_in);
      rd_req_out  <= 1'b1;
      rd_addr_out <= addr;
      @(posedge clock_in);
      rd_req_out  <= 1'b0;
      rd_addr_out <= ~addr;
      @(negedge clock_in);
      data  = rd_data_in;
      valid = rd_valid_in;
   endtask
endmodule // query_host_model
`default_nettype wire

// ===== cfi_primary_ext_query_rom_bench.sv
// self-checking bench of the extended query table block
`timescale 1ns/1ps
`default_nettype none
`include "cfi_query_cfg.svh"
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module cfi_primary_ext_query_rom_bench;
   logic        clock_in, reset_n_in, psel, penable, pwrite, suspend;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_out, rd;
   logic        pready_out, pslverr_out, er, cmd_valid, rd_req, rd_valid_out, query_mode_out, v;
   logic [7:0]  cmd_code, rd_addr;
   logic [15:0] rd_data_out, d, d0;
   int          num_errors, checks, cycles;
   logic [15:0] exp_word [0:15] = '{16'h0031, 16'h0030, 16'h00E6, 16'h0003, 16'h0000, 16'h0000,
      16'h0001, 16'h0003, 16'h0000, 16'h0018, 16'h00C0, 16'h0001, 16'h0080, 16'h0000, 16'h0003, 16'h0004};
   logic [7:0]  cmd_tab [0:2] = '{`CMD_READ_ARRAY, `CMD_READ_STATUS, `CMD_QUERY};

   cfi_primary_ext_query_rom cfi_primary_ext_query_rom_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .suspend_in(suspend), .rd_req_in(rd_req),
      .rd_addr_in(rd_addr), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
      .query_mode_out(query_mode_out));
   query_host_model query_host_model_i (.clock_in(clock_in), .cmd_valid_out(cmd_valid),
      .cmd_code_out(cmd_code), .rd_req_out(rd_req), .rd_addr_out(rd_addr), .rd_data_in(rd_data_out),
      .rd_valid_in(rd_valid_out));
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   // whole run is under 150 cycles
   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // zero wait states expected, but the master waits for pready anyway
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
      @(posedge clock_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wdata;
      @(posedge clock_in);
      penable <= 1'b1;
      do
      begin
         @(posedge clock_in);
      end
      while (pready_out !== 1'b1);
      rdata = prdata_out;
      err   = pslverr_out;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~wdata;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      suspend = 1'b0;
      reset_n_in = 1'b0;
      num_errors = 0;
      checks = 0;
      cycles = 0;
      repeat (16) @(posedge clock_in);
      reset_n_in <= 1'b1;
      apb(1'b0, `APB_OFF_BASE, 32'h0, rd, er);
      `CHECK(rd, 32'h0000_0039)
      `CHECK({er, pready_out}, 2'b01)
      apb(1'b0, `APB_OFF_STATUS, 32'h0, rd, er);
      `CHECK(rd, 32'h0000_0000)
      query_host_model_i.q_read(8'h3C, d, v);
      `CHECK(d, 16'h0000)
      $display("test reset_and_array_mode done");
      query_host_model_i.send_cmd(`CMD_QUERY);
      `CHECK(query_mode_out, 1'b1)
      for (int i = 0; i < 16; i++)
      begin
         query_host_model_i.q_read(8'h3C + 8'(i), d, v);
         `CHECK({v, d}, {1'b1, exp_word[i]})
      end
      @(negedge clock_in);
      `CHECK(rd_valid_out, 1'b0)
      query_host_model_i.q_read(8'h3E, d0, v);
      query_host_model_i.q_read(8'h3F, d, v);
      `CHECK({d[7:0], d0[7:0]}, 16'h03E6)
      query_host_model_i.q_read(8'h3B, d, v);
      `CHECK(d, 16'h0000)
      query_host_model_i.q_read(8'h4C, d, v);
      `CHECK(d, 16'h0000)
      $display("test table_walk done");
      apb(1'b1, `APB_OFF_BASE, 32'h0000_0050, rd, er);
      query_host_model_i.q_read(8'h53, d, v);
      `CHECK(d, 16'h0031)
      apb(1'b1, `APB_OFF_ADDR, 32'h0000_005E, rd, er);
      apb(1'b0, `APB_OFF_ADDR, 32'h0, rd, er);
      `CHECK(rd, 32'h0000_005E)
      apb(1'b0, `APB_OFF_DATA, 32'h0, rd, er);
      `CHECK(rd, 32'h0000_0001)
      apb(1'b1, `APB_OFF_BASE, 32'h0000_0039, rd, er);
      $display("test moved_base done");
      suspend <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         query_host_model_i.send_cmd(cmd_tab[i]);
         apb(1'b0, `APB_OFF_STATUS, 32'h0, rd, er);
         `CHECK(rd, 32'h4 | 32'(i))
      end
      query_host_model_i.send_cmd(8'h40);
      apb(1'b0, `APB_OFF_STATUS, 32'h0, rd, er);
      `CHECK(rd, 32'h0000_000E)
      apb(1'b1, `APB_OFF_STATUS, 32'h0000_0008, rd, er);
      apb(1'b0, `APB_OFF_STATUS, 32'h0, rd, er);
      `CHECK(rd, 32'h0000_0006)
      query_host_model_i.q_read(8'h45, d, v);
      `CHECK(d, 16'h0018)
      suspend <= 1'b0;
      apb(1'b0, 12'h010, 32'h0, rd, er);
      `CHECK({er, rd}, {1'b1, 32'h0})
      $display("test suspend_and_refusal done");
      print_verdict();
   end
endmodule // cfi_primary_ext_query_rom_bench
`default_nettype wire
